// file: logic/rid_pkg.sv
// constants and types for the risc instruction decoder
// Overview of operation
// - every instruction is one 32-bit word
// - classify into immediate, jump or register layout
// - accept all three architecture levels unchanged
// - memory transfers are immediate-layout, registers only
// - address is base plus sign-extended 16-bit offset
// - all widths, signedness, partial, linked, sync
// - register forms all registers; immediate uses imm16
// - separate immediate, register, shift, multiply groups
// - arithmetic and logic ops, word and doubleword
// - doubleword shifts with plus 32 amount
// - left, logical right, arithmetic right; constant, variable
// - multiply/divide use result regs, with moves
// - one delay slot after every jump/branch not itself in a slot
// - likely branch nullifies slot when not taken
// - compare and zero-sign branches, link, likely
// - jumps to target or register, with link
package rid_pkg;

  // ---------------------------------------------------------------
  // field layout of the 32-bit word
  // ---------------------------------------------------------------
  localparam int INSN_W = 32;
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 26;
  localparam int RS_MSB = 25;
  localparam int RS_LSB = 21;
  localparam int RT_MSB = 20;
  localparam int RT_LSB = 16;
  localparam int RD_MSB = 15;
  localparam int RD_LSB = 11;
  localparam int SA_MSB = 10;
  localparam int SA_LSB = 6;
  localparam int FN_MSB = 5;
  localparam int IMM_W = 16;
  localparam int JT_W = 26;
  localparam int XLEN = 64;
  localparam logic [4:0] LINK_REG = 5'h1f;

  // ---------------------------------------------------------------
  // primary opcodes
  // ---------------------------------------------------------------
  localparam logic [5:0] OPC_SPECIAL = 6'h00, OPC_REGIMM = 6'h01,
    OPC_J = 6'h02, OPC_JAL = 6'h03, OPC_BEQ = 6'h04, OPC_BNE = 6'h05,
    OPC_BLEZ = 6'h06, OPC_BGTZ = 6'h07, OPC_ADDI = 6'h08,
    OPC_ADDIU = 6'h09, OPC_SLTI = 6'h0a, OPC_SLTIU = 6'h0b,
    OPC_ANDI = 6'h0c, OPC_ORI = 6'h0d, OPC_XORI = 6'h0e,
    OPC_LUI = 6'h0f, OPC_BEQL = 6'h14, OPC_BNEL = 6'h15,
    OPC_BLEZL = 6'h16, OPC_BGTZL = 6'h17, OPC_DADDI = 6'h18,
    OPC_DADDIU = 6'h19, OPC_LDL = 6'h1a, OPC_LDR = 6'h1b,
    OPC_LB = 6'h20, OPC_LH = 6'h21, OPC_LWL = 6'h22, OPC_LW = 6'h23,
    OPC_LBU = 6'h24, OPC_LHU = 6'h25, OPC_LWR = 6'h26,
    OPC_LWU = 6'h27, OPC_SB = 6'h28, OPC_SH = 6'h29,
    OPC_SWL = 6'h2a, OPC_SW = 6'h2b, OPC_SDL = 6'h2c,
    OPC_SDR = 6'h2d, OPC_SWR = 6'h2e, OPC_LL = 6'h30,
    OPC_LLD = 6'h34, OPC_LD = 6'h37, OPC_SC = 6'h38,
    OPC_SCD = 6'h3c, OPC_SD = 6'h3f;

  // ---------------------------------------------------------------
  // register-layout function codes
  // ---------------------------------------------------------------
  localparam logic [5:0] FN_SLL = 6'h00, FN_SRL = 6'h02,
    FN_SRA = 6'h03, FN_SLLV = 6'h04, FN_SRLV = 6'h06,
    FN_SRAV = 6'h07, FN_JR = 6'h08, FN_JALR = 6'h09,
    FN_SYNC = 6'h0f, FN_MF_UP = 6'h10, FN_MT_UP = 6'h11,
    FN_MF_LOW = 6'h12, FN_MT_LOW = 6'h13, FN_DSLLV = 6'h14,
    FN_DSRLV = 6'h16, FN_DSRAV = 6'h17, FN_MULT = 6'h18,
    FN_MULTU = 6'h19, FN_DIV = 6'h1a, FN_DIVU = 6'h1b,
    FN_DMULT = 6'h1c, FN_DMULTU = 6'h1d, FN_DDIV = 6'h1e,
    FN_DDIVU = 6'h1f, FN_ADD = 6'h20, FN_ADDU = 6'h21,
    FN_SUB = 6'h22, FN_SUBU = 6'h23, FN_AND = 6'h24, FN_OR = 6'h25,
    FN_XOR = 6'h26, FN_NOR = 6'h27, FN_SLT = 6'h2a,
    FN_SLTU = 6'h2b, FN_DADD = 6'h2c, FN_DADDU = 6'h2d,
    FN_DSUB = 6'h2e, FN_DSUBU = 6'h2f, FN_DSLL = 6'h38,
    FN_DSRL = 6'h3a, FN_DSRA = 6'h3b, FN_DSLL32 = 6'h3c,
    FN_DSRL32 = 6'h3e, FN_DSRA32 = 6'h3f;

  // zero-sign branch selectors in the rt field
  localparam logic [4:0] RT_BLTZ = 5'h00, RT_BGEZ = 5'h01,
    RT_BLTZL = 5'h02, RT_BGEZL = 5'h03, RT_BLTZAL = 5'h10,
    RT_BGEZAL = 5'h11, RT_BLTZALL = 5'h12, RT_BGEZALL = 5'h13;

  // ---------------------------------------------------------------
  // decoded control types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {FMT_IMM, FMT_JMP, FMT_REG} rid_fmt_t;
  typedef enum logic [3:0] {CLS_NONE, CLS_LOAD, CLS_STORE, CLS_SYNC,
    CLS_ALU_IMM, CLS_ALU_REG, CLS_SHIFT, CLS_MULDIV, CLS_JUMP,
    CLS_BRANCH} rid_cls_t;
  typedef enum logic [4:0] {AOP_NONE, AOP_ADD, AOP_ADDU, AOP_SUB,
    AOP_SUBU, AOP_SLT, AOP_SLTU, AOP_AND, AOP_OR, AOP_XOR, AOP_NOR,
    AOP_LUI, AOP_SLL, AOP_SRL, AOP_SRA, AOP_MULT, AOP_MULTU,
    AOP_DIV, AOP_DIVU, AOP_FROM_UPPER, AOP_TO_UPPER, AOP_FROM_LOWER,
    AOP_TO_LOWER} rid_aop_t;
  typedef enum logic [1:0] {MW_BYTE, MW_HALF, MW_WORD,
    MW_DWORD} rid_mw_t;
  typedef enum logic [1:0] {MP_FULL, MP_LEFT, MP_RIGHT} rid_mp_t;
  typedef enum logic [2:0] {BC_NONE, BC_ALWAYS, BC_EQ, BC_NE, BC_LEZ,
    BC_GTZ, BC_LTZ, BC_GEZ} rid_bc_t;

endpackage

// file: logic/rid_decoder.sv
// instruction decoder with delay-slot tracking
`timescale 1ns/1ps
module rid_decoder
  import rid_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // from fetch
  input wire logic instr_valid,
  input wire logic [INSN_W-1:0] instr_word,
  // branch outcome for the slot now presented
  input wire logic br_taken,
  // decoded controls
  output logic dec_valid_r,
  output rid_fmt_t dec_fmt_r,
  output rid_cls_t dec_class_r,
  output rid_aop_t dec_alu_op_r,
  output logic dec_dword_r,
  output logic [4:0] dec_rs_r,
  output logic [4:0] dec_rt_r,
  output logic [4:0] dec_dest_r,
  output logic dec_src2_imm_r,
  output logic [XLEN-1:0] dec_imm_r,
  output logic [5:0] dec_shamt_r,
  output logic dec_shift_var_r,
  output rid_mw_t dec_mem_width_r,
  output logic dec_mem_unsigned_r,
  output rid_mp_t dec_mem_part_r,
  output logic dec_mem_linked_r,
  output rid_bc_t dec_br_cond_r,
  output logic dec_likely_r,
  output logic dec_link_r,
  output logic dec_jump_reg_r,
  output logic [JT_W-1:0] dec_jtarget_r,
  // slot and exception status
  output logic dec_delay_slot_r,
  output logic dec_nullify_r,
  output logic dec_reserved_r
);

  // ---------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {DS_IDLE, DS_SLOT, DS_LIKELY} rid_ds_t;

  logic [5:0] op;
  logic [5:0] fn;
  logic [4:0] rtf;
  logic [4:0] sa;
  logic [IMM_W-1:0] imm;

  // whole word is one instruction
  assign op = instr_word[OP_MSB:OP_LSB];
  assign fn = instr_word[FN_MSB:0];
  assign rtf = instr_word[RT_MSB:RT_LSB];
  assign sa = instr_word[SA_MSB:SA_LSB];
  assign imm = instr_word[IMM_W-1:0];

  rid_fmt_t fmt_nxt;
  rid_cls_t cls_nxt;
  rid_aop_t aop_nxt;
  rid_mw_t mw_nxt;
  rid_mp_t mp_nxt;
  rid_bc_t bc_nxt;
  logic dw_nxt;
  logic [4:0] dest_nxt;
  logic src2_nxt;
  logic [XLEN-1:0] imm_nxt;
  logic [5:0] sh_nxt;
  logic shvar_nxt;
  logic mu_nxt;
  logic ml_nxt;
  logic lkl_nxt;
  logic lk_nxt;
  logic jr_nxt;
  logic rsv_nxt;

  // logic op from the two low code bits
  function automatic rid_aop_t logic_op(input logic [1:0] k);
    rid_aop_t r;
    unique case (k)
      2'h0: r = AOP_AND;
      2'h1: r = AOP_OR;
      2'h2: r = AOP_XOR;
      2'h3: r = AOP_NOR;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // instruction decode, levels one to three
  // ---------------------------------------------------------------
  always_comb begin
    fmt_nxt = FMT_IMM;
    cls_nxt = CLS_NONE;
    aop_nxt = AOP_NONE;
    dw_nxt = 1'b0;
    dest_nxt = rtf;
    src2_nxt = 1'b0;
    imm_nxt = {{(XLEN-IMM_W){imm[IMM_W-1]}}, imm};
    sh_nxt = {1'b0, sa};
    shvar_nxt = 1'b0;
    bc_nxt = BC_NONE;
    lkl_nxt = 1'b0;
    lk_nxt = 1'b0;
    jr_nxt = 1'b0;
    rsv_nxt = 1'b0;
    case (op)
      OPC_SPECIAL: begin
        fmt_nxt = FMT_REG;
        dest_nxt = instr_word[RD_MSB:RD_LSB];
        case (fn)
          FN_SLL, FN_SRL, FN_SRA, FN_SLLV, FN_SRLV, FN_SRAV,
          FN_DSLLV, FN_DSRLV, FN_DSRAV, FN_DSLL, FN_DSRL, FN_DSRA,
          FN_DSLL32, FN_DSRL32, FN_DSRA32: begin
            cls_nxt = CLS_SHIFT;
            // direction from low bits, variable from bit 2 when bit 5 is clear
            aop_nxt = (fn[1:0] == 2'h0) ? AOP_SLL :
                      (fn[0] ? AOP_SRA : AOP_SRL);
            dw_nxt = fn[4] | fn[5];
            shvar_nxt = ~fn[5] & fn[2];
            sh_nxt = {fn[5] & fn[2], sa};
          end
          FN_ADD, FN_ADDU, FN_SUB, FN_SUBU,
          FN_DADD, FN_DADDU, FN_DSUB, FN_DSUBU: begin
            cls_nxt = CLS_ALU_REG;
            dw_nxt = fn[3];
            aop_nxt = fn[1] ? (fn[0] ? AOP_SUBU : AOP_SUB) :
                              (fn[0] ? AOP_ADDU : AOP_ADD);
          end
          FN_AND, FN_OR, FN_XOR, FN_NOR: begin
            cls_nxt = CLS_ALU_REG;
            aop_nxt = logic_op(fn[1:0]);
          end
          FN_SLT, FN_SLTU: begin
            cls_nxt = CLS_ALU_REG;
            aop_nxt = fn[0] ? AOP_SLTU : AOP_SLT;
          end
          FN_MULT, FN_MULTU, FN_DIV, FN_DIVU,
          FN_DMULT, FN_DMULTU, FN_DDIV, FN_DDIVU: begin
            // results land in the upper/lower result regs
            cls_nxt = CLS_MULDIV;
            dw_nxt = fn[2];
            aop_nxt = fn[1] ? (fn[0] ? AOP_DIVU : AOP_DIV) :
                              (fn[0] ? AOP_MULTU : AOP_MULT);
          end
          FN_MF_UP: begin
            cls_nxt = CLS_MULDIV;
            aop_nxt = AOP_FROM_UPPER;
          end
          FN_MT_UP: begin
            cls_nxt = CLS_MULDIV;
            aop_nxt = AOP_TO_UPPER;
          end
          FN_MF_LOW: begin
            cls_nxt = CLS_MULDIV;
            aop_nxt = AOP_FROM_LOWER;
          end
          FN_MT_LOW: begin
            cls_nxt = CLS_MULDIV;
            aop_nxt = AOP_TO_LOWER;
          end
          FN_JR, FN_JALR: begin
            cls_nxt = CLS_JUMP;
            bc_nxt = BC_ALWAYS;
            jr_nxt = 1'b1;
            lk_nxt = fn[0];
          end
          FN_SYNC: cls_nxt = CLS_SYNC;
          default: rsv_nxt = 1'b1;
        endcase
      end
      OPC_REGIMM: begin
        cls_nxt = CLS_BRANCH;
        case (rtf)
          RT_BLTZ, RT_BGEZ, RT_BLTZL, RT_BGEZL,
          RT_BLTZAL, RT_BGEZAL, RT_BLTZALL, RT_BGEZALL: begin
            bc_nxt = rtf[0] ? BC_GEZ : BC_LTZ;
            lkl_nxt = rtf[1];
            lk_nxt = rtf[4];
            dest_nxt = LINK_REG;
          end
          default: rsv_nxt = 1'b1;
        endcase
      end
      OPC_J, OPC_JAL: begin
        fmt_nxt = FMT_JMP;
        cls_nxt = CLS_JUMP;
        bc_nxt = BC_ALWAYS;
        lk_nxt = op[0];
        dest_nxt = LINK_REG;
      end
      OPC_BEQ, OPC_BNE, OPC_BLEZ, OPC_BGTZ,
      OPC_BEQL, OPC_BNEL, OPC_BLEZL, OPC_BGTZL: begin
        cls_nxt = CLS_BRANCH;
        lkl_nxt = op[4];
        unique case (op[1:0])
          2'h0: bc_nxt = BC_EQ;
          2'h1: bc_nxt = BC_NE;
          2'h2: bc_nxt = BC_LEZ;
          2'h3: bc_nxt = BC_GTZ;
        endcase
      end
      OPC_ADDI, OPC_ADDIU, OPC_DADDI, OPC_DADDIU: begin
        cls_nxt = CLS_ALU_IMM;
        src2_nxt = 1'b1;
        dw_nxt = op[4];
        aop_nxt = op[0] ? AOP_ADDU : AOP_ADD;
      end
      OPC_SLTI, OPC_SLTIU: begin
        cls_nxt = CLS_ALU_IMM;
        src2_nxt = 1'b1;
        aop_nxt = op[0] ? AOP_SLTU : AOP_SLT;
      end
      OPC_ANDI, OPC_ORI, OPC_XORI, OPC_LUI: begin
        cls_nxt = CLS_ALU_IMM;
        src2_nxt = 1'b1;
        imm_nxt = {{(XLEN-IMM_W){1'b0}}, imm};
        aop_nxt = (op == OPC_LUI) ? AOP_LUI : logic_op(op[1:0]);
      end
      OPC_LB, OPC_LBU, OPC_LH, OPC_LHU, OPC_LW, OPC_LWU, OPC_LWL,
      OPC_LWR, OPC_LD, OPC_LDL, OPC_LDR, OPC_LL, OPC_LLD: begin
        cls_nxt = CLS_LOAD;
        src2_nxt = 1'b1;
      end
      OPC_SB, OPC_SH, OPC_SW, OPC_SWL, OPC_SWR, OPC_SD, OPC_SDL,
      OPC_SDR, OPC_SC, OPC_SCD: begin
        cls_nxt = CLS_STORE;
        src2_nxt = 1'b1;
      end
      default: rsv_nxt = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // memory access attributes
  // ---------------------------------------------------------------
  always_comb begin
    mw_nxt = MW_WORD;
    mp_nxt = MP_FULL;
    mu_nxt = 1'b0;
    ml_nxt = 1'b0;
    case (op)
      OPC_LB, OPC_SB: mw_nxt = MW_BYTE;
      OPC_LH, OPC_SH: mw_nxt = MW_HALF;
      OPC_LWL, OPC_SWL: mp_nxt = MP_LEFT;
      OPC_LWR, OPC_SWR: mp_nxt = MP_RIGHT;
      OPC_LWU: mu_nxt = 1'b1;
      OPC_LL, OPC_SC: ml_nxt = 1'b1;
      OPC_LD, OPC_SD: mw_nxt = MW_DWORD;
      OPC_LBU: begin
        mw_nxt = MW_BYTE;
        mu_nxt = 1'b1;
      end
      OPC_LHU: begin
        mw_nxt = MW_HALF;
        mu_nxt = 1'b1;
      end
      OPC_LDL, OPC_SDL: begin
        mw_nxt = MW_DWORD;
        mp_nxt = MP_LEFT;
      end
      OPC_LDR, OPC_SDR: begin
        mw_nxt = MW_DWORD;
        mp_nxt = MP_RIGHT;
      end
      OPC_LLD, OPC_SCD: begin
        mw_nxt = MW_DWORD;
        ml_nxt = 1'b1;
      end
      default: mw_nxt = MW_WORD;
    endcase
  end

  // ---------------------------------------------------------------
  // delay-slot tracking
  // ---------------------------------------------------------------
  rid_ds_t ds_r;
  rid_ds_t ds_nxt;
  logic cti;
  logic slot_nxt;
  logic null_nxt;

  assign cti = (cls_nxt == CLS_JUMP || cls_nxt == CLS_BRANCH) &&
               !rsv_nxt;

  // arm after a jump/branch; a transfer inside a slot does not arm
  always_comb begin
    ds_nxt = ds_r;
    slot_nxt = 1'b0;
    null_nxt = 1'b0;
    if (instr_valid) begin
      unique case (ds_r)
        DS_IDLE: if (cti) begin
          ds_nxt = lkl_nxt ? DS_LIKELY : DS_SLOT;
        end
        DS_SLOT: begin
          slot_nxt = 1'b1;
          ds_nxt = DS_IDLE;
        end
        DS_LIKELY: begin
          slot_nxt = 1'b1;
          null_nxt = !br_taken;
          ds_nxt = DS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ds_r <= DS_IDLE;
      dec_valid_r <= 1'b0;
      dec_fmt_r <= FMT_IMM;
      dec_class_r <= CLS_NONE;
      dec_alu_op_r <= AOP_NONE;
      dec_dword_r <= 1'b0;
      dec_rs_r <= '0;
      dec_rt_r <= '0;
      dec_dest_r <= '0;
      dec_src2_imm_r <= 1'b0;
      dec_imm_r <= '0;
      dec_shamt_r <= '0;
      dec_shift_var_r <= 1'b0;
      dec_mem_width_r <= MW_WORD;
      dec_mem_unsigned_r <= 1'b0;
      dec_mem_part_r <= MP_FULL;
      dec_mem_linked_r <= 1'b0;
      dec_br_cond_r <= BC_NONE;
      dec_likely_r <= 1'b0;
      dec_link_r <= 1'b0;
      dec_jump_reg_r <= 1'b0;
      dec_jtarget_r <= '0;
      dec_delay_slot_r <= 1'b0;
      dec_nullify_r <= 1'b0;
      dec_reserved_r <= 1'b0;
    end else begin
      ds_r <= ds_nxt;
      dec_valid_r <= instr_valid;
      dec_fmt_r <= fmt_nxt;
      dec_class_r <= cls_nxt;
      dec_alu_op_r <= aop_nxt;
      dec_dword_r <= dw_nxt | (mw_nxt == MW_DWORD);
      dec_rs_r <= instr_word[RS_MSB:RS_LSB];
      dec_rt_r <= rtf;
      dec_dest_r <= dest_nxt;
      dec_src2_imm_r <= src2_nxt;
      dec_imm_r <= imm_nxt;
      dec_shamt_r <= sh_nxt;
      dec_shift_var_r <= shvar_nxt;
      dec_mem_width_r <= mw_nxt;
      dec_mem_unsigned_r <= mu_nxt;
      dec_mem_part_r <= mp_nxt;
      dec_mem_linked_r <= ml_nxt;
      dec_br_cond_r <= bc_nxt;
      dec_likely_r <= lkl_nxt;
      dec_link_r <= lk_nxt;
      dec_jump_reg_r <= jr_nxt;
      dec_jtarget_r <= instr_word[JT_W-1:0];
      dec_delay_slot_r <= slot_nxt;
      dec_nullify_r <= null_nxt;
      dec_reserved_r <= instr_valid & rsv_nxt;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_valid_follows;
    instr_valid |=> dec_valid_r;
  endproperty
  a_valid_follows: assert property (p_valid_follows)
    else $error("decoded valid missing");

  property p_jump_fmt;
    instr_valid && op == OPC_JAL |=>
      dec_fmt_r == FMT_JMP && dec_link_r && dec_dest_r == LINK_REG;
  endproperty
  a_jump_fmt: assert property (p_jump_fmt)
    else $error("jump layout wrong");

  property p_mem_imm;
    dec_valid_r && (dec_class_r == CLS_LOAD ||
      dec_class_r == CLS_STORE) |-> dec_fmt_r == FMT_IMM;
  endproperty
  a_mem_imm: assert property (p_mem_imm)
    else $error("memory op not immediate layout");

  property p_offset_sext;
    instr_valid && op == OPC_LW |=> dec_src2_imm_r &&
      dec_imm_r == {{(XLEN-IMM_W){$past(instr_word[IMM_W-1])}},
      $past(instr_word[IMM_W-1:0])};
  endproperty
  a_offset_sext: assert property (p_offset_sext)
    else $error("offset not sign extended");

  property p_lhu_attr;
    instr_valid && op == OPC_LHU |=> dec_class_r == CLS_LOAD &&
      dec_mem_width_r == MW_HALF && dec_mem_unsigned_r;
  endproperty
  a_lhu_attr: assert property (p_lhu_attr)
    else $error("unsigned halfword load wrong");

  property p_reg_src;
    dec_valid_r && dec_class_r == CLS_ALU_REG |-> !dec_src2_imm_r &&
      dec_fmt_r == FMT_REG;
  endproperty
  a_reg_src: assert property (p_reg_src)
    else $error("register op uses immediate");

  property p_shift32;
    instr_valid && op == OPC_SPECIAL && fn == FN_DSRA32 |=>
      dec_shamt_r == {1'b1, $past(sa)} && dec_alu_op_r == AOP_SRA;
  endproperty
  a_shift32: assert property (p_shift32)
    else $error("plus 32 shift amount wrong");

  property p_ddiv;
    instr_valid && op == OPC_SPECIAL && fn == FN_DDIVU |=>
      dec_class_r == CLS_MULDIV && dec_dword_r &&
      dec_alu_op_r == AOP_DIVU;
  endproperty
  a_ddiv: assert property (p_ddiv)
    else $error("doubleword divide decode wrong");

  property p_slot_next;
    ds_r != DS_IDLE && instr_valid |=> dec_delay_slot_r &&
      ds_r == DS_IDLE;
  endproperty
  a_slot_next: assert property (p_slot_next)
    else $error("delay slot not marked");

  property p_null_likely;
    dec_delay_slot_r |-> dec_nullify_r ==
      ($past(ds_r) == DS_LIKELY && !$past(br_taken));
  endproperty
  a_null_likely: assert property (p_null_likely)
    else $error("likely nullify wrong");

  property p_reserved;
    instr_valid && op == 6'h3b |=> dec_reserved_r && ds_r == DS_IDLE;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved encoding not flagged");

  c_load: cover property (dec_valid_r && dec_class_r == CLS_LOAD);
  c_slot: cover property (dec_delay_slot_r && !dec_nullify_r);
  c_null: cover property (dec_delay_slot_r && dec_nullify_r);
  c_rsv: cover property (dec_reserved_r);

endmodule

// file: sim/rid_fetch_model.sv
// fetch unit model that hands whole words to the decoder
`timescale 1ns/1ps
module rid_fetch_model
  import rid_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // requests from the bench
  input wire logic push,
  input wire logic [INSN_W-1:0] push_word,
  input wire logic push_taken,
  // towards the decoder
  output logic instr_valid,
  output logic [INSN_W-1:0] instr_word,
  output logic br_taken
);
  // one 32-bit word per cycle; idle lines flip so stale data never repeats
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      instr_valid <= 1'b0;
      instr_word <= 32'h0;
      br_taken <= 1'b0;
    end else begin
      instr_valid <= push;
      instr_word <= push ? push_word : ~instr_word;
      br_taken <= push ? push_taken : ~br_taken;
    end
  end
endmodule

// file: sim/risc_instruction_decode_test.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module risc_instruction_decode_test;
  import rid_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic push = 1'b0;
  logic push_taken = 1'b0;
  logic [INSN_W-1:0] push_word = 32'h0;
  logic instr_valid, br_taken;
  logic [INSN_W-1:0] instr_word;
  logic dec_valid_r, dec_dword_r, dec_src2_imm_r, dec_shift_var_r;
  logic dec_mem_unsigned_r, dec_mem_linked_r, dec_likely_r, dec_link_r;
  logic dec_jump_reg_r, dec_delay_slot_r, dec_nullify_r, dec_reserved_r;
  rid_fmt_t dec_fmt_r;
  rid_cls_t dec_class_r;
  rid_aop_t dec_alu_op_r;
  rid_mw_t dec_mem_width_r;
  rid_mp_t dec_mem_part_r;
  rid_bc_t dec_br_cond_r;
  logic [4:0] dec_dest_r, dec_rs_r, dec_rt_r;
  logic [JT_W-1:0] dec_jtarget_r;
  logic [XLEN-1:0] dec_imm_r;
  logic [5:0] dec_shamt_r;
  int fails = 0;
  int cmp_count = 0;
  logic [2:0] seen_q[$];
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  rid_fetch_model u_rid_fetch_model (.core_clk, .rst_n, .push, .push_word,
    .push_taken, .instr_valid, .instr_word, .br_taken);
  rid_decoder u_rid_decoder (.core_clk, .rst_n, .instr_valid, .instr_word,
    .br_taken, .dec_valid_r, .dec_fmt_r, .dec_class_r, .dec_alu_op_r,
    .dec_dword_r, .dec_rs_r, .dec_rt_r, .dec_dest_r, .dec_src2_imm_r,
    .dec_imm_r, .dec_shamt_r, .dec_shift_var_r, .dec_mem_width_r,
    .dec_mem_unsigned_r, .dec_mem_part_r, .dec_mem_linked_r,
    .dec_br_cond_r, .dec_likely_r, .dec_link_r, .dec_jump_reg_r,
    .dec_jtarget_r, .dec_delay_slot_r, .dec_nullify_r, .dec_reserved_r);
  // slot, nullify and reserved status of every valid decoded word
  always @(negedge core_clk) begin
    if (dec_valid_r === 1'b1) begin
      seen_q.push_back({dec_delay_slot_r, dec_nullify_r, dec_reserved_r});
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] mk_b(logic [5:0] op, logic [4:0] rt);
    return {op, 5'h4, rt, 16'h8001};
  endfunction
  function automatic logic [31:0] mk_r(logic [4:0] sa, logic [5:0] fn);
    return {OPC_SPECIAL, 5'h4, 5'h5, 5'h6, sa, fn};
  endfunction
  task automatic check(logic [63:0] seen, logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic feed(logic [31:0] w, logic v, logic tk);
    @(posedge core_clk);
    push <= v;
    push_word <= w;
    push_taken <= tk;
  endtask
  // present one word, then look at its decode two cycles later
  task automatic dec1(logic [31:0] w);
    feed(w, 1'b1, 1'b0);
    feed(~w, 1'b0, 1'b0);
    @(posedge core_clk);
    #1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic mem(logic [5:0] op, rid_cls_t c, rid_mw_t mw, rid_mp_t p,
    logic [1:0] ul);
    dec1(mk_b(op, 5'h2));
    check(dec_fmt_r, FMT_IMM);
    check(dec_class_r, c);
    check(dec_imm_r, 64'hffffffffffff8001);
    check(dec_src2_imm_r, 1'b1);
    check({dec_rs_r, dec_rt_r}, 10'h82);
    check(dec_mem_width_r, mw);
    check({dec_mem_unsigned_r, dec_mem_linked_r}, ul);
    check(dec_mem_part_r, p);
  endtask
  task automatic t_mem();
    mem(OPC_LB, CLS_LOAD, MW_BYTE, MP_FULL, 2'h0);
    mem(OPC_LW, CLS_LOAD, MW_WORD, MP_FULL, 2'h0);
    mem(OPC_LHU, CLS_LOAD, MW_HALF, MP_FULL, 2'h2);
    mem(OPC_LWU, CLS_LOAD, MW_WORD, MP_FULL, 2'h2);
    mem(OPC_LWL, CLS_LOAD, MW_WORD, MP_LEFT, 2'h0);
    mem(OPC_LDR, CLS_LOAD, MW_DWORD, MP_RIGHT, 2'h0);
    mem(OPC_LLD, CLS_LOAD, MW_DWORD, MP_FULL, 2'h1);
    mem(OPC_SC, CLS_STORE, MW_WORD, MP_FULL, 2'h1);
    mem(OPC_SDL, CLS_STORE, MW_DWORD, MP_LEFT, 2'h0);
    mem(OPC_SWR, CLS_STORE, MW_WORD, MP_RIGHT, 2'h0);
    dec1(mk_r(5'h0, FN_SYNC));
    check(dec_class_r, CLS_SYNC);
    $display("t_mem done");
  endtask
  task automatic alu(logic [31:0] w, rid_cls_t c, rid_aop_t a, logic d);
    dec1(w);
    check(dec_fmt_r, (w[31:26] == 6'h0) ? FMT_REG : FMT_IMM);
    check(dec_class_r, c);
    check(dec_alu_op_r, a);
    check(dec_src2_imm_r, w[31:26] != 6'h0);
    check(dec_dest_r, (w[31:26] == 6'h0) ? 5'h6 : 5'h2);
    if (d !== 1'bx) check(dec_dword_r, d);
  endtask
  task automatic t_alu();
    alu(mk_b(OPC_ADDI, 5'h2), CLS_ALU_IMM, AOP_ADD, 1'b0);
    check(dec_imm_r, 64'hffffffffffff8001);
    alu(mk_b(OPC_ANDI, 5'h2), CLS_ALU_IMM, AOP_AND, 1'b0);
    check(dec_imm_r, 64'h8001);
    alu(mk_b(OPC_DADDIU, 5'h2), CLS_ALU_IMM, AOP_ADDU, 1'b1);
    alu(mk_b(OPC_SLTIU, 5'h2), CLS_ALU_IMM, AOP_SLTU, 1'b0);
    alu(mk_r(5'h0, FN_SUB), CLS_ALU_REG, AOP_SUB, 1'b0);
    alu(mk_r(5'h0, FN_DSUBU), CLS_ALU_REG, AOP_SUBU, 1'b1);
    alu(mk_r(5'h0, FN_NOR), CLS_ALU_REG, AOP_NOR, 1'b0);
    alu(mk_r(5'h0, FN_XOR), CLS_ALU_REG, AOP_XOR, 1'b0);
    alu(mk_r(5'h0, FN_SLT), CLS_ALU_REG, AOP_SLT, 1'b0);
    alu(mk_r(5'h0, FN_MULTU), CLS_MULDIV, AOP_MULTU, 1'b0);
    alu(mk_r(5'h0, FN_DDIV), CLS_MULDIV, AOP_DIV, 1'b1);
    alu(mk_r(5'h0, FN_DDIVU), CLS_MULDIV, AOP_DIVU, 1'b1);
    alu(mk_b(OPC_LUI, 5'h2), CLS_ALU_IMM, AOP_LUI, 1'b0);
    alu(mk_r(5'h0, FN_MF_UP), CLS_MULDIV, AOP_FROM_UPPER, 1'bx);
    alu(mk_r(5'h0, FN_MT_LOW), CLS_MULDIV, AOP_TO_LOWER, 1'bx);
    $display("t_alu done");
  endtask
  task automatic sh(logic [5:0] fn, logic [4:0] sa, rid_aop_t a,
    logic [1:0] dv, logic [5:0] amt);
    dec1(mk_r(sa, fn));
    check(dec_class_r, CLS_SHIFT);
    check(dec_alu_op_r, a);
    check({dec_dword_r, dec_shift_var_r}, dv);
    if (!dv[0]) check(dec_shamt_r, amt);
  endtask
  task automatic t_shift();
    sh(FN_SLL, 5'h1f, AOP_SLL, 2'h0, 6'h1f);
    sh(FN_SRL, 5'h01, AOP_SRL, 2'h0, 6'h01);
    sh(FN_SRAV, 5'h00, AOP_SRA, 2'h1, 6'h00);
    sh(FN_DSRA, 5'h04, AOP_SRA, 2'h2, 6'h04);
    sh(FN_DSLLV, 5'h00, AOP_SLL, 2'h3, 6'h00);
    sh(FN_DSLL32, 5'h00, AOP_SLL, 2'h2, 6'h20);
    sh(FN_DSRL32, 5'h1f, AOP_SRL, 2'h2, 6'h3f);
    sh(FN_DSRA32, 5'h05, AOP_SRA, 2'h2, 6'h25);
    $display("t_shift done");
  endtask
  task automatic jb(logic [31:0] w, rid_fmt_t f, rid_bc_t bc,
    logic [2:0] flg);
    dec1(w);
    check(dec_fmt_r, f);
    check(dec_class_r, (bc == BC_ALWAYS) ? CLS_JUMP : CLS_BRANCH);
    check(dec_br_cond_r, bc);
    check({dec_likely_r, dec_link_r, dec_jump_reg_r}, flg);
  endtask
  task automatic t_jump();
    jb(mk_b(OPC_JAL, 5'h0), FMT_JMP, BC_ALWAYS, 3'h2);
    check(dec_dest_r, LINK_REG);
    check(dec_jtarget_r, 26'h808001);
    jb(mk_b(OPC_J, 5'h0), FMT_JMP, BC_ALWAYS, 3'h0);
    jb(mk_r(5'h0, FN_JR), FMT_REG, BC_ALWAYS, 3'h1);
    jb(mk_r(5'h0, FN_JALR), FMT_REG, BC_ALWAYS, 3'h3);
    jb(mk_b(OPC_BNEL, 5'h5), FMT_IMM, BC_NE, 3'h4);
    jb(mk_b(OPC_BLEZ, 5'h0), FMT_IMM, BC_LEZ, 3'h0);
    jb(mk_b(OPC_BGTZL, 5'h0), FMT_IMM, BC_GTZ, 3'h4);
    jb(mk_b(OPC_REGIMM, RT_BGEZL), FMT_IMM, BC_GEZ, 3'h4);
    jb(mk_b(OPC_REGIMM, RT_BLTZAL), FMT_IMM, BC_LTZ, 3'h2);
    jb(mk_b(OPC_REGIMM, RT_BGEZALL), FMT_IMM, BC_GEZ, 3'h6);
    $display("t_jump done");
  endtask
  // pairs of branch and slot, with a bubble, nesting and a reserved word
  task automatic t_slot();
    logic [2:0] exp [14];
    logic [31:0] add_w;
    add_w = mk_r(5'h0, FN_ADD);
    exp = '{3'h0, 3'h0, 3'h6, 3'h0, 3'h4, 3'h0, 3'h4, 3'h0, 3'h4, 3'h0,
      3'h1, 3'h0, 3'h0, 3'h6};
    feed(add_w, 1'b1, 1'b0);
    seen_q.delete();
    feed(mk_b(OPC_BEQL, 5'h5), 1'b1, 1'b0);
    feed(add_w, 1'b1, 1'b0);
    feed(mk_b(OPC_BEQL, 5'h5), 1'b1, 1'b0);
    feed(add_w, 1'b1, 1'b1);
    feed(mk_b(OPC_BEQ, 5'h5), 1'b1, 1'b1);
    feed(add_w, 1'b0, 1'b0);
    feed(add_w, 1'b1, 1'b0);
    feed(mk_b(OPC_J, 5'h0), 1'b1, 1'b0);
    feed(mk_b(OPC_BNE, 5'h5), 1'b1, 1'b0);
    feed(add_w, 1'b1, 1'b0);
    feed(mk_b(6'h3b, 5'h0), 1'b1, 1'b0);
    feed(add_w, 1'b1, 1'b0);
    feed(mk_b(OPC_REGIMM, RT_BLTZALL), 1'b1, 1'b1);
    feed(add_w, 1'b1, 1'b0);
    repeat (3) feed(add_w, 1'b0, 1'b0);
    check(seen_q.size(), 14);
    foreach (exp[i]) check(seen_q[i], exp[i]);
    $display("t_slot done");
  endtask
  // ------------------------------------------------------------
  // sequence and verdict
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    t_mem();
    t_alu();
    t_shift();
    t_jump();
    t_slot();
    tally_and_finish();
  end
  // cut a hang short
  initial begin
    #100us;
    fails++;
    tally_and_finish();
  end
endmodule
